// File: inc/iws_consts.svh
`ifndef IWS_CONSTS_SVH
`define IWS_CONSTS_SVH

// interrupt vector and stack step
`define IWS_VECTOR       16'h0010
`define IWS_SP_STEP      8'h02
`define IWS_SP_ONE       8'h01

// request line positions
`define IWS_LINE_PA0     0
`define IWS_LINE_PB0     1
`define IWS_LINE_TMR     2

// edge select fields
`define IWS_EDGE_BOTH    2'h0
`define IWS_EDGE_RISE    2'h1
`define IWS_EDGE_FALL    2'h2
`define IWS_ES_PA0_LSB   0
`define IWS_ES_PB0_LSB   2
`define IWS_ES_TMR_BIT   4

// timer mode setting fields
`define IWS_TM_SRC_MSB   7
`define IWS_TM_SRC_LSB   5
`define IWS_TM_PRE_MSB   4
`define IWS_TM_PRE_LSB   3
`define IWS_TM_SEL_MSB   2
`define IWS_TM_SEL_LSB   0
`define IWS_SEL_BASE     4'h8
`define IWS_SRC_STOP     3'h0
`define IWS_SRC_CORE     3'h1
`define IWS_SRC_FASTRC   3'h4
`define IWS_SRC_XTAL     3'h5
`define IWS_SRC_SLOWRC   3'h6
`define IWS_SRC_PINA0    3'h7
`define IWS_PRE_1        2'h0
`define IWS_PRE_4        2'h1
`define IWS_PRE_16       2'h2
`define IWS_PRE_64       2'h3
`define IWS_MASK_1       6'h00
`define IWS_MASK_4       6'h03
`define IWS_MASK_16      6'h0F
`define IWS_MASK_64      6'h3F

// watchdog timeouts, slow rc periods minus one
`define IWS_WDT_MODE_2K  2'h0
`define IWS_WDT_MODE_4K  2'h1
`define IWS_WDT_LIM_2K   14'h07FF
`define IWS_WDT_LIM_4K   14'h0FFF
`define IWS_WDT_LIM_16K  14'h3FFF

// wake-up delays minus one
`define IWS_WAKE_NORMAL  10'h3FF
`define IWS_WAKE_FAST    10'h07F

`endif

// File: inc/iws_pkg.sv
package iws_pkg;

	typedef enum logic [7:0] {
		ST_RUN     = 8'h01,
		ST_SAVE_LO = 8'h02,
		ST_SAVE_HI = 8'h04,
		ST_REST_LO = 8'h08,
		ST_REST_HI = 8'h10,
		ST_LSLEEP  = 8'h20,
		ST_DSLEEP  = 8'h40,
		ST_WAKE    = 8'h80
	} iws_fsm_t;

	typedef struct packed {
		logic engint;
		logic disgint;
		logic wdreset;
		logic lightSleep;
		logic deepSleep;
		logic reti;
		logic pushAf;
		logic popAf;
		logic boundary;
	} iws_cmd_t;

	typedef struct packed {
		logic coreTick;
		logic fastRcTick;
		logic slowRcTick;
		logic crystalTick;
		logic fastRcEn;
		logic slowRcEn;
		logic crystalEn;
	} iws_osc_t;

	typedef struct packed {
		logic       memWrite;
		logic       memRead;
		logic [7:0] memAddr;
		logic [7:0] memWData;
	} iws_mem_t;

	typedef struct packed {
		logic        pcLoad;
		logic [15:0] pcValue;
		logic        accLoad;
		logic [7:0]  accValue;
		logic        flagLoad;
		logic [7:0]  flagValue;
	} iws_load_t;

	typedef struct packed {
		logic coreClockOn;
		logic progMemOff;
		logic oscStop;
		logic deviceReset;
		logic coreHalt;
	} iws_power_t;

	typedef struct packed {
		iws_fsm_t    fsm;
		logic        irqCall;
		logic        gie;
		logic [2:0]  intrq;
		logic [7:0]  stackPointer;
		logic [15:0] savedWord;
		logic [7:0]  lowByte;
		logic [2:0]  linePrev;
		logic [15:0] wakePrev;
		logic [5:0]  prescale;
		logic [15:0] timerCount;
		logic [13:0] watchdog;
		logic [9:0]  wakeCount;
		logic        wakeFast;
		iws_mem_t    mem;
		iws_load_t   ld;
		iws_power_t  pwr;
	} iws_regs_t;

endpackage

// File: verilog/iws_control.sv
`include "iws_consts.svh"
`timescale 1ns/1ns
`default_nettype none

module iws_control (
	// clock and reset
	input  wire logic               clock,
	input  wire logic               nrst,
	// core commands and data
	input  wire iws_pkg::iws_cmd_t  cmd,
	input  wire logic [15:0]        pcIn,
	input  wire logic [7:0]         accIn,
	input  wire logic [7:0]         flagIn,
	input  wire logic               spWrite,
	input  wire logic [7:0]         spWriteData,
	// interrupt configuration
	input  wire logic [2:0]         intEnable,
	input  wire logic [7:0]         edgeSelect,
	input  wire logic               reqWrite,
	input  wire logic [2:0]         reqWriteData,
	// timer configuration
	input  wire logic [7:0]         timerModeSetting,
	input  wire logic               timerLoad,
	input  wire logic [15:0]        timerLoadValue,
	// watchdog and wake configuration
	input  wire logic               watchdogEnable,
	input  wire logic [1:0]         watchdogMode,
	input  wire logic               fastWake,
	// oscillators
	input  wire iws_pkg::iws_osc_t  osc,
	// pins
	input  wire logic               portA0,
	input  wire logic               portB0,
	input  wire logic [15:0]        wakePins,
	input  wire logic [15:0]        wakeEnable,
	// stack memory
	input  wire logic [7:0]         memRData,
	output logic                    memWrite,
	output logic                    memRead,
	output logic [7:0]              memAddr,
	output logic [7:0]              memWData,
	// core loads
	output iws_pkg::iws_load_t      coreLoad,
	// status
	output logic [2:0]              intrq,
	output logic                    globalEnable,
	output logic [7:0]              stackPointer,
	output logic [15:0]             timerCount,
	output iws_pkg::iws_power_t     power
);

	iws_pkg::iws_regs_t r;
	iws_pkg::iws_regs_t next_r;

	logic [2:0]       lineNow;
	logic [2:0]       lineEvent;
	logic [2:0][1:0]  lineMode;
	logic [3:0]       selIdx;
	logic             srcTick;
	logic [5:0]       preMask;
	logic             preTick;
	logic [13:0]      wdtLimit;
	logic             wdtTimeout;
	logic             pinToggle;
	logic             pending;

	function automatic iws_pkg::iws_regs_t initRegs();
		iws_pkg::iws_regs_t v;
		v = '0;
		v.fsm = iws_pkg::ST_RUN;
		v.pwr.coreClockOn = 1'b1;
		return v;
	endfunction

	// selected counter bit and edge sources
	assign selIdx = `IWS_SEL_BASE + {1'b0, timerModeSetting[`IWS_TM_SEL_MSB:`IWS_TM_SEL_LSB]};
	assign lineNow = {r.timerCount[selIdx], portB0, portA0};
	assign lineMode[`IWS_LINE_PA0] = edgeSelect[`IWS_ES_PA0_LSB +: 2];
	assign lineMode[`IWS_LINE_PB0] = edgeSelect[`IWS_ES_PB0_LSB +: 2];
	assign lineMode[`IWS_LINE_TMR] = edgeSelect[`IWS_ES_TMR_BIT] ? `IWS_EDGE_FALL
		: `IWS_EDGE_RISE;

	genvar gi;
	generate
		for (gi = 0; gi < 3; gi++) begin : g_edge
			assign lineEvent[gi] =
				(lineNow[gi] & ~r.linePrev[gi] & (lineMode[gi] != `IWS_EDGE_FALL)) |
				(~lineNow[gi] & r.linePrev[gi] & (lineMode[gi] != `IWS_EDGE_RISE));
		end
	endgenerate

	// timer clock source, gated in deep sleep; core clock source also gated in light sleep
	always_comb begin
		unique case (timerModeSetting[`IWS_TM_SRC_MSB:`IWS_TM_SRC_LSB])
			`IWS_SRC_CORE:   srcTick = osc.coreTick & r.pwr.coreClockOn;
			`IWS_SRC_FASTRC: srcTick = osc.fastRcTick & osc.fastRcEn;
			`IWS_SRC_XTAL:   srcTick = osc.crystalTick & osc.crystalEn;
			`IWS_SRC_SLOWRC: srcTick = osc.slowRcTick & osc.slowRcEn;
			`IWS_SRC_PINA0:  srcTick = portA0 & ~r.linePrev[`IWS_LINE_PA0];
			default:         srcTick = 1'b0;
		endcase
		unique case (timerModeSetting[`IWS_TM_PRE_MSB:`IWS_TM_PRE_LSB])
			`IWS_PRE_1:  preMask = `IWS_MASK_1;
			`IWS_PRE_4:  preMask = `IWS_MASK_4;
			`IWS_PRE_16: preMask = `IWS_MASK_16;
			`IWS_PRE_64: preMask = `IWS_MASK_64;
		endcase
		unique case (watchdogMode)
			`IWS_WDT_MODE_2K: wdtLimit = `IWS_WDT_LIM_2K;
			`IWS_WDT_MODE_4K: wdtLimit = `IWS_WDT_LIM_4K;
			default:          wdtLimit = `IWS_WDT_LIM_16K;
		endcase
	end

	assign preTick = srcTick & ~r.pwr.oscStop & ((r.prescale & preMask) == preMask);
	assign wdtTimeout = watchdogEnable & ~cmd.wdreset & osc.slowRcTick & ~r.pwr.oscStop
		& (r.watchdog == wdtLimit);
	assign pinToggle = |((wakePins ^ r.wakePrev) & wakeEnable);
	assign pending = r.gie & |(r.intrq & intEnable);

	always_comb begin
		next_r = r;
		next_r.ld.pcLoad = 1'b0;
		next_r.ld.accLoad = 1'b0;
		next_r.ld.flagLoad = 1'b0;
		next_r.pwr.deviceReset = 1'b0;
		next_r.linePrev = lineNow;
		next_r.wakePrev = wakePins;

		// request flags: set wins over a clearing write
		next_r.intrq = (reqWrite ? (r.intrq & reqWriteData) : r.intrq) | lineEvent;

		// timer
		if (srcTick & ~r.pwr.oscStop) begin
			next_r.prescale = r.prescale + 6'h01;
		end
		if (timerLoad) begin
			next_r.timerCount = timerLoadValue;
		end else if (preTick) begin
			next_r.timerCount = r.timerCount + 16'h0001;
		end

		// watchdog
		if (cmd.wdreset || !watchdogEnable) begin
			next_r.watchdog = '0;
		end else if (osc.slowRcTick && !r.pwr.oscStop) begin
			next_r.watchdog = r.watchdog + 14'h0001;
		end

		if (spWrite) begin
			next_r.stackPointer = spWriteData;
		end

		unique case (r.fsm)
			iws_pkg::ST_RUN: begin
				if (cmd.engint) begin
					next_r.gie = 1'b1;
				end else if (cmd.disgint) begin
					next_r.gie = 1'b0;
				end
				if (pending && cmd.boundary) begin
					next_r.irqCall = 1'b1;
					next_r.savedWord = pcIn;
					next_r.mem.memWrite = 1'b1;
					next_r.mem.memAddr = r.stackPointer;
					next_r.mem.memWData = pcIn[7:0];
					next_r.pwr.coreHalt = 1'b1;
					next_r.fsm = iws_pkg::ST_SAVE_LO;
				end else if (cmd.reti || cmd.popAf) begin
					next_r.irqCall = cmd.reti;
					next_r.mem.memRead = 1'b1;
					next_r.mem.memAddr = r.stackPointer - `IWS_SP_STEP;
					next_r.pwr.coreHalt = 1'b1;
					next_r.fsm = iws_pkg::ST_REST_LO;
				end else if (cmd.pushAf) begin
					next_r.irqCall = 1'b0;
					next_r.savedWord = {flagIn, accIn};
					next_r.mem.memWrite = 1'b1;
					next_r.mem.memAddr = r.stackPointer;
					next_r.mem.memWData = accIn;
					next_r.pwr.coreHalt = 1'b1;
					next_r.fsm = iws_pkg::ST_SAVE_LO;
				end else if (cmd.lightSleep || cmd.deepSleep) begin
					next_r.pwr.coreClockOn = 1'b0;
					next_r.pwr.progMemOff = 1'b1;
					next_r.pwr.oscStop = cmd.deepSleep;
					next_r.pwr.coreHalt = 1'b1;
					next_r.wakeFast = cmd.lightSleep & fastWake & ~osc.crystalEn;
					next_r.fsm = cmd.deepSleep ? iws_pkg::ST_DSLEEP : iws_pkg::ST_LSLEEP;
				end
			end
			iws_pkg::ST_SAVE_LO: begin
				next_r.mem.memAddr = r.stackPointer + `IWS_SP_ONE;
				next_r.mem.memWData = r.savedWord[15:8];
				next_r.fsm = iws_pkg::ST_SAVE_HI;
			end
			iws_pkg::ST_SAVE_HI: begin
				next_r.mem.memWrite = 1'b0;
				next_r.stackPointer = r.stackPointer + `IWS_SP_STEP;
				if (r.irqCall) begin
					next_r.gie = 1'b0;
					next_r.ld.pcLoad = 1'b1;
					next_r.ld.pcValue = `IWS_VECTOR;
				end
				next_r.pwr.coreHalt = 1'b0;
				next_r.fsm = iws_pkg::ST_RUN;
			end
			iws_pkg::ST_REST_LO: begin
				next_r.lowByte = memRData;
				next_r.mem.memAddr = r.stackPointer - `IWS_SP_ONE;
				next_r.fsm = iws_pkg::ST_REST_HI;
			end
			iws_pkg::ST_REST_HI: begin
				next_r.mem.memRead = 1'b0;
				next_r.stackPointer = r.stackPointer - `IWS_SP_STEP;
				if (r.irqCall) begin
					next_r.gie = 1'b1;
					next_r.ld.pcLoad = 1'b1;
					next_r.ld.pcValue = {memRData, r.lowByte};
				end else begin
					next_r.ld.accLoad = 1'b1;
					next_r.ld.accValue = r.lowByte;
					next_r.ld.flagLoad = 1'b1;
					next_r.ld.flagValue = memRData;
				end
				next_r.pwr.coreHalt = 1'b0;
				next_r.fsm = iws_pkg::ST_RUN;
			end
			iws_pkg::ST_LSLEEP: begin
				if (pinToggle || lineEvent[`IWS_LINE_TMR]) begin
					next_r.wakeCount = '0;
					next_r.fsm = iws_pkg::ST_WAKE;
				end
			end
			iws_pkg::ST_DSLEEP: begin
				if (pinToggle) begin
					next_r.pwr.oscStop = 1'b0;
					next_r.wakeCount = '0;
					next_r.fsm = iws_pkg::ST_WAKE;
				end
			end
			iws_pkg::ST_WAKE: begin
				if (r.wakeFast ? osc.coreTick : osc.slowRcTick) begin
					if (r.wakeCount == (r.wakeFast ? `IWS_WAKE_FAST : `IWS_WAKE_NORMAL)) begin
						next_r.pwr.coreClockOn = 1'b1;
						next_r.pwr.progMemOff = 1'b0;
						next_r.pwr.coreHalt = 1'b0;
						next_r.fsm = iws_pkg::ST_RUN;
					end else begin
						next_r.wakeCount = r.wakeCount + 10'h001;
					end
				end
			end
		endcase

		if (wdtTimeout) begin
			next_r = initRegs();
			next_r.pwr.deviceReset = 1'b1;
		end
	end

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			r <= initRegs();
		end else begin
			r <= next_r;
		end
	end

	// outputs
	assign memWrite = r.mem.memWrite;
	assign memRead = r.mem.memRead;
	assign memAddr = r.mem.memAddr;
	assign memWData = r.mem.memWData;
	assign coreLoad = r.ld;
	assign intrq = r.intrq;
	assign globalEnable = r.gie;
	assign stackPointer = r.stackPointer;
	assign timerCount = r.timerCount;
	assign power = r.pwr;

endmodule

`default_nettype wire

// File: test/iws_stack_mem.sv
`timescale 1ns/1ns
`default_nettype none

module iws_stack_mem (
	// clock
	input  wire logic       clock,
	// stack memory port
	input  wire logic       memWrite,
	input  wire logic       memRead,
	input  wire logic [7:0] memAddr,
	input  wire logic [7:0] memWData,
	output logic [7:0]      memRData
);
	logic [7:0] mem [256];
	logic [7:0] lastData = 8'h00;

	always @(posedge clock) begin
		if (memWrite) begin
			mem[memAddr] <= memWData;
		end
		if (memRead) begin
			lastData <= mem[memAddr];
		end
	end

	// released bus shows the inverse of the last word
	assign memRData = memRead ? mem[memAddr] : ~lastData;
endmodule

`default_nettype wire

// File: test/iws_control_monitor.sv
`include "iws_consts.svh"
`timescale 1ns/1ns
`default_nettype none

module iws_control_monitor (
	// clock and reset
	input wire logic                clock,
	input wire logic                nrst,
	// watched ports
	input wire iws_pkg::iws_cmd_t   cmd,
	input wire logic [7:0]          accIn,
	input wire logic [7:0]          flagIn,
	input wire logic [2:0]          intEnable,
	input wire logic [7:0]          edgeSelect,
	input wire logic                reqWrite,
	input wire logic [7:0]          timerModeSetting,
	input wire logic [15:0]         wakePins,
	input wire logic                portA0,
	input wire logic                memWrite,
	input wire logic [7:0]          memWData,
	input wire iws_pkg::iws_load_t  coreLoad,
	input wire logic [2:0]          intrq,
	input wire logic                globalEnable,
	input wire logic [7:0]          stackPointer,
	input wire logic [15:0]         timerCount,
	input wire iws_pkg::iws_power_t power
);
	default clocking @(posedge clock); endclocking
	default disable iff (!nrst);
	logic ready;
	logic take;
	logic selBit;
	assign ready = !power.coreHalt && power.coreClockOn;
	assign take = ready && cmd.boundary && globalEnable && |(intrq & intEnable);
	assign selBit = timerCount[{1'b1, timerModeSetting[2:0]}];

	property p_entry;
		take |=> memWrite ##2 coreLoad.pcLoad && coreLoad.pcValue == `IWS_VECTOR
			&& !globalEnable && stackPointer == $past(stackPointer, 3) + `IWS_SP_STEP;
	endproperty
	a_entry: assert property (p_entry) else $error("bad interrupt entry");
	property p_reti;
		ready && cmd.reti && !take |-> ##3 coreLoad.pcLoad && globalEnable
			&& stackPointer == $past(stackPointer, 3) - `IWS_SP_STEP;
	endproperty
	a_reti: assert property (p_reti) else $error("bad return");
	property p_push;
		ready && cmd.pushAf && !take |=> memWrite && memWData == $past(accIn)
			##1 memWData == $past(flagIn, 2);
	endproperty
	a_push: assert property (p_push) else $error("bad push");
	property p_rise;
		$rose(portA0) && edgeSelect[1:0] == `IWS_EDGE_RISE |=> intrq[0];
	endproperty
	a_rise: assert property (p_rise) else $error("pin flag missed");
	property p_hold;
		!reqWrite |=> ((intrq & $past(intrq)) == $past(intrq)) || power.deviceReset;
	endproperty
	a_hold: assert property (p_hold) else $error("flag lost");
	property p_timer;
		(edgeSelect[4] ? $fell(selBit) : $rose(selBit)) && $stable(timerModeSetting)
			|-> ##[1:3] intrq[2];
	endproperty
	a_timer: assert property (p_timer) else $error("timer flag missed");
	property p_light;
		ready && cmd.lightSleep && !take |=> !power.coreClockOn && power.progMemOff
			&& !power.oscStop && power.coreHalt;
	endproperty
	a_light: assert property (p_light) else $error("bad light sleep");
	property p_deep;
		power.oscStop && $stable(wakePins) && $past(wakePins) == $past(wakePins, 2)
			|=> power.oscStop;
	endproperty
	a_deep: assert property (p_deep) else $error("deep sleep left");

	c_entry: cover property (take);
	c_wake: cover property ($rose(power.coreClockOn));
	c_dog: cover property (power.deviceReset);
endmodule

bind iws_control iws_control_monitor iws_control_monitor_inst (.*);

`default_nettype wire

// File: test/iws_control_test.sv
`include "iws_consts.svh"
`timescale 1ns/1ns
`default_nettype none

module iws_control_test;
	logic                clock, nrst, spWrite, reqWrite, timerLoad, watchdogEnable, fastWake;
	logic                portA0, portB0, memWrite, memRead, globalEnable, sawPc;
	iws_pkg::iws_cmd_t   cmd;
	iws_pkg::iws_osc_t   osc;
	iws_pkg::iws_load_t  coreLoad;
	iws_pkg::iws_power_t power;
	logic [15:0]         pcIn, timerLoadValue, timerCount, wakePins, wakeEnable, pc;
	logic [7:0]          accIn, flagIn, spWriteData, edgeSelect, timerModeSetting;
	logic [7:0]          memRData, memAddr, memWData, stackPointer, sp, acc, flg;
	logic [2:0]          intEnable, reqWriteData, intrq;
	logic [1:0]          watchdogMode;
	int                  errorCnt, checked, n, p;

	iws_control iws_control_inst (.*);
	iws_stack_mem iws_stack_mem_inst (.*);

	function automatic int wdLimit(input int m);
		return m == 0 ? 2048 : (m == 1 ? 4096 : 16384);
	endfunction
	function automatic logic edgeHit(input int m, input logic rise);
		return rise ? (m != 2) : (m != 1);
	endfunction
	task cyc(input int k);
		repeat (k) @(posedge clock);
		#1;
	endtask
	task pulse(input iws_pkg::iws_cmd_t c);
		cmd <= c;
		cyc(1);
		cmd <= '0;
	endtask
	task clr(input logic [2:0] d);
		reqWriteData <= d;
		reqWrite <= 1'b1;
		cyc(1);
		reqWrite <= 1'b0;
	endtask
	task setPin(input int l, input logic v);
		if (l == 0) portA0 <= v;
		else portB0 <= v;
		cyc(2);
	endtask
	task reload;
		timerLoad <= 1'b1;
		cyc(1);
		timerLoad <= 1'b0;
		cyc(3);
		clr(3'h0);
	endtask
	task check(input logic [15:0] seen, input logic [15:0] exp);
		checked++;
		if (seen !== exp) begin
			errorCnt++;
			$display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
		end
	endtask
	task stopTest;
		$display("errors %0d checks %0d", errorCnt, checked);
		if (errorCnt == 0 && checked > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask

	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end
	initial begin
		#900000;
		errorCnt++;
		stopTest();
	end

	initial begin
		errorCnt = 0; checked = 0; nrst = 1'b0; cmd = '0; pcIn = '0; accIn = '0;
		flagIn = '0; spWrite = 0; spWriteData = '0; intEnable = '0; edgeSelect = '0;
		reqWrite = 0; reqWriteData = '0; timerModeSetting = '0; timerLoad = 0;
		timerLoadValue = '0; watchdogEnable = 0; watchdogMode = '0; fastWake = 0;
		portA0 = 0; portB0 = 0; wakePins = '0; wakeEnable = '0;
		osc = 7'h76;
		void'($urandom(32'hA570F550));
		cyc(16);
		nrst <= 1'b1;
		cyc(1);
		for (int l = 0; l < 2; l++) for (int m = 0; m < 4; m++) begin
			edgeSelect <= 8'(m << (2 * l));
			clr(3'h0);
			setPin(l, 1'b1);
			check(intrq[l], edgeHit(m, 1'b1));
			clr(3'h0);
			setPin(l, 1'b0);
			check(intrq[l], edgeHit(m, 1'b0));
		end
		setPin(0, 1'b1); setPin(1, 1'b1); clr(3'h6);
		check(intrq, 3'h2);
		clr(3'h7);
		check(intrq, 3'h2);
		setPin(0, 1'b0);
		sp = (8'($urandom) & 8'hE0) | 8'h10;
		pc = 16'($urandom);
		spWriteData <= sp; spWrite <= 1'b1; cyc(1); spWrite <= 1'b0;
		pulse(9'h100);
		check(globalEnable, 1'b1);
		intEnable <= 3'h4; pcIn <= pc; pulse(9'h001); cyc(4);
		check(stackPointer, sp);
		intEnable <= 3'h1; pulse(9'h001);
		for (n = 0; n < 8 && !coreLoad.pcLoad; n++) cyc(1);
		check(coreLoad.pcValue, `IWS_VECTOR);
		check(stackPointer, sp + 8'h02);
		check(globalEnable, 1'b0);
		check({iws_stack_mem_inst.mem[sp + 8'h01], iws_stack_mem_inst.mem[sp]}, pc);
		acc = 8'($urandom); flg = 8'($urandom); accIn <= acc; flagIn <= flg;
		pulse(9'h004); cyc(4); accIn <= ~acc;
		check({iws_stack_mem_inst.mem[sp + 8'h03], iws_stack_mem_inst.mem[sp + 8'h02]},
			{flg, acc});
		pulse(9'h002);
		for (n = 0; n < 8 && !coreLoad.accLoad; n++) cyc(1);
		check({coreLoad.flagValue, coreLoad.accValue}, {flg, acc});
		check(memRead, 1'b0);
		cyc(1); pulse(9'h008);
		for (n = 0; n < 8 && !coreLoad.pcLoad; n++) cyc(1);
		check(coreLoad.pcValue, pc);
		check({stackPointer, 7'h00, globalEnable}, {sp, 8'h01});
		cyc(1); pulse(9'h080);
		check(globalEnable, 1'b0);
		edgeSelect <= 8'h10;
		for (p = 0; p < 4; p++) begin
			n = 1 << (2 * p);
			timerModeSetting <= {`IWS_SRC_FASTRC, 2'(p), 3'h0};
			reload();
			cyc(511 * n - 6);
			check(intrq[2], 1'b0);
			cyc(n + 6);
			check(intrq[2], 1'b1);
		end
		timerModeSetting <= {`IWS_SRC_PINA0, 5'h00};
		reload();
		for (p = 1; p <= 512; p++) begin
			setPin(0, 1'b1); setPin(0, 1'b0);
			if (p == 511) check(intrq[2], 1'b0);
		end
		check(intrq[2], 1'b1);
		timerModeSetting <= 8'h00;
		for (int m = 0; m < 3; m++) begin
			spWrite <= 1'b1; cyc(1); spWrite <= 1'b0;
			watchdogMode <= 2'(m); watchdogEnable <= 1'b1; cyc(1000);
			pulse(9'h040);
			for (n = 0; n < 17000 && !power.deviceReset; n++) cyc(1);
			watchdogEnable <= 1'b0;
			check(n > wdLimit(m) - 4 && n < wdLimit(m) + 4, 1'b1);
			cyc(1);
			check(stackPointer, 8'h00);
			check(timerCount, 16'h0000);
		end
		wakeEnable <= 16'h0008;
		for (int f = 0; f < 3; f++) begin
			fastWake <= (f == 0);
			pulse(f == 2 ? 9'h010 : 9'h020);
			check(power, f == 2 ? 5'h0D : 5'h09);
			wakePins <= wakePins ^ 16'h0020; cyc(20);
			check(power.coreClockOn, 1'b0);
			wakePins <= wakePins ^ 16'h0008; sawPc = 0;
			for (n = 0; n < 2000 && !power.coreClockOn; n++) begin
				cyc(1);
				sawPc |= coreLoad.pcLoad;
			end
			check(n > (f == 0 ? 124 : 1020) && n < (f == 0 ? 132 : 1028), 1'b1);
			check({power, sawPc}, 6'h20);
			cyc(2);
		end
		stopTest();
	end
endmodule

`default_nettype wire
